// ===== hw/t2c_consts.svh
// Offsets, field positions, reset values and counts for the timer control block.
// Included by the design modules and the checker; definitions only.
`ifndef T2C_CONSTS_SVH
`define T2C_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define T2C_PAGE          8'h00
`define T2C_CTRL_ADDR     8'hc8
`define T2C_RLD_LO_ADDR   8'hca
`define T2C_RLD_HI_ADDR   8'hcb
`define T2C_CNT_LO_ADDR   8'hcc
`define T2C_CNT_HI_ADDR   8'hcd
`define T2C_CTRL_RESET    8'h00
`define T2C_BYTE_RESET    8'h00

// ****************************************************************
// Control register fields
// ****************************************************************
`define T2C_BIT_HIGH_FLAG 7
`define T2C_BIT_LOW_FLAG  6
`define T2C_BIT_LOW_IRQ   5
`define T2C_BIT_CAPTURE   4
`define T2C_BIT_SPLIT     3
`define T2C_BIT_RUN       2
`define T2C_BIT_UNUSED    1
`define T2C_BIT_EXT_CLK   0
`define T2C_WRITE_MASK    8'hfd

// ****************************************************************
// Counts
// ****************************************************************
`define T2C_BYTE_MAX      8'hff
`define T2C_WORD_MAX      16'hffff
`define T2C_DIV12_LAST    4'hb
`define T2C_EXT_TICK_AT   3'h3
`define T2C_EXT_FALL_AT   3'h7

`endif

// ===== hw/t2c_pkg.sv
// Types shared by the timer control block and its tick generator.
// Assumes t2c_consts.svh is on the include path.
package t2c_pkg;

    typedef enum logic
    {
        T2C_MODE_WORD  = 1'b0,
        T2C_MODE_SPLIT = 1'b1
    } t2c_mode_e;

    typedef struct packed
    {
        logic      high_overflow_flag;
        logic      low_overflow_flag;
        logic      low_byte_irq_enable;
        logic      capture_mode_enable;
        t2c_mode_e split_mode_select;
        logic      run_control;
        logic      unused;
        logic      ext_clock_select;
    } t2c_ctrl_s;

    typedef struct packed
    {
        logic div12_tick;
        logic ext8_tick;
        logic ext8_fall;
    } t2c_ticks_s;

endpackage

// ===== hw/t2c_ticks.sv
// Tick generator: core clock divided by 12 and external clock divided by 8.
// Assumes the external clock input is sampled on the core clock.
`timescale 1ns/100ps
`include "t2c_consts.svh"

module t2c_ticks
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              ext_clk_in,
    output t2c_pkg::t2c_ticks_s    ticks_out
);
    import t2c_pkg::*;

    logic       ext_sync1;
    logic       ext_sync2;
    logic       ext_prev;
    logic [2:0] ext_div;
    logic [3:0] div12;
    t2c_ticks_s next_ticks;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire ext_rise   = ext_sync2 & ~ext_prev;
    wire div12_wrap = (div12 == `T2C_DIV12_LAST);

    assign next_ticks.div12_tick = div12_wrap;
    assign next_ticks.ext8_tick  = ext_rise && (ext_div == `T2C_EXT_TICK_AT);
    // Divided clock falls as the divider wraps back to zero
    assign next_ticks.ext8_fall  = ext_rise && (ext_div == `T2C_EXT_FALL_AT);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev  <= 1'b0;
            ext_div   <= 3'h0;
            div12     <= 4'h0;
            ticks_out <= '0;
        end
        else
        begin
            ext_sync1 <= ext_clk_in;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
            ext_div   <= ext_rise ? ext_div + 3'h1 : ext_div;
            div12     <= div12_wrap ? 4'h0 : div12 + 4'h1;
            ticks_out <= next_ticks;
        end
    end

endmodule // t2c_ticks

// ===== hw/t2c_timer.sv
// Timer 2 control, counter, reload and capture logic behind the SFR bus.
// Assumes the SFR bus signals are synchronous to REF_CLK_IN and a write lasts one cycle.
`timescale 1ns/100ps
`include "t2c_consts.svh"

module t2c_timer
(
    input  wire logic       REF_CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic [7:0] SFR_ADDR_IN,
    input  wire logic [7:0] SFR_PAGE_IN,
    input  wire logic       SFR_WR_IN,
    input  wire logic [7:0] SFR_WDATA_IN,
    input  wire logic       SFR_BIT_WR_IN,
    input  wire logic [2:0] SFR_BIT_SEL_IN,
    input  wire logic       SFR_BIT_VAL_IN,
    input  wire logic       TIMER_IRQ_ENABLE_IN,
    input  wire logic       HIGH_FAST_CLOCK_SELECT_IN,
    input  wire logic       LOW_FAST_CLOCK_SELECT_IN,
    input  wire logic       EXT_CLK_IN,
    output logic [7:0]      SFR_RDATA_OUT,
    output logic            TIMER_IRQ_OUT
);
    import t2c_pkg::*;

    t2c_ctrl_s   timer_control_reg;
    t2c_ctrl_s   next_ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] next_count;
    logic [15:0] next_reload;
    logic        set_high;
    logic        set_low;
    t2c_ticks_s  ticks;

    // ****************************************************************
    // Tick sources
    // ****************************************************************
    t2c_ticks u_ticks
    (
        .clk_in     (REF_CLK_IN),
        .rst_in     (RST_IN),
        .ext_clk_in (EXT_CLK_IN),
        .ticks_out  (ticks)
    );

    wire       ext_sel    = timer_control_reg.ext_clock_select;
    wire       slow_tick  = ext_sel ? ticks.ext8_tick : ticks.div12_tick;
    wire       low_tick   = LOW_FAST_CLOCK_SELECT_IN  | slow_tick;
    wire       high_tick  = HIGH_FAST_CLOCK_SELECT_IN | slow_tick;
    wire       run        = timer_control_reg.run_control;
    wire       split      = (timer_control_reg.split_mode_select == T2C_MODE_SPLIT);
    wire       capture    = timer_control_reg.capture_mode_enable && ticks.ext8_fall;

    // ****************************************************************
    // SFR decode
    // ****************************************************************
    wire       page_hit   = (SFR_PAGE_IN == `T2C_PAGE);
    wire       ctrl_hit   = page_hit && (SFR_ADDR_IN == `T2C_CTRL_ADDR);
    wire       rll_hit    = page_hit && (SFR_ADDR_IN == `T2C_RLD_LO_ADDR);
    wire       rlh_hit    = page_hit && (SFR_ADDR_IN == `T2C_RLD_HI_ADDR);
    wire       cntl_hit   = page_hit && (SFR_ADDR_IN == `T2C_CNT_LO_ADDR);
    wire       cnth_hit   = page_hit && (SFR_ADDR_IN == `T2C_CNT_HI_ADDR);
    wire       ctrl_byte  = SFR_WR_IN && ctrl_hit;
    wire       ctrl_bit   = SFR_BIT_WR_IN && ctrl_hit;
    wire [7:0] bit_mask   = 8'h01 << SFR_BIT_SEL_IN;
    wire [7:0] bit_value  = (timer_control_reg & ~bit_mask) | (SFR_BIT_VAL_IN ? bit_mask : 8'h00);
    wire [7:0] ctrl_wdata = ctrl_byte ? SFR_WDATA_IN : bit_value;
    wire [7:0] ctrl_write = (ctrl_byte || ctrl_bit) ? ctrl_wdata : timer_control_reg;

    wire [7:0] read_mux   = ctrl_hit ? (timer_control_reg & `T2C_WRITE_MASK) :
                            rll_hit  ? reload[7:0]  :
                            rlh_hit  ? reload[15:8] :
                            cntl_hit ? count[7:0]   :
                            cnth_hit ? count[15:8]  : 8'h00;

    // ****************************************************************
    // Control next value
    // ****************************************************************
    always_comb
    begin
        next_ctrl                    = t2c_ctrl_s'(ctrl_write & `T2C_WRITE_MASK);
        // Hardware sets win over a software clear in the same cycle
        next_ctrl.high_overflow_flag = next_ctrl.high_overflow_flag | set_high;
        next_ctrl.low_overflow_flag  = next_ctrl.low_overflow_flag  | set_low;
    end

    // ****************************************************************
    // Counter next value
    // ****************************************************************
    always_comb
    begin
        next_count = count;
        set_high   = 1'b0;
        set_low    = 1'b0;
        if (!split)
        begin
            if (run && low_tick)
            begin
                if (count == `T2C_WORD_MAX)
                begin
                    next_count = reload;
                    set_high   = 1'b1;
                    set_low    = 1'b1;
                end
                else
                begin
                    next_count = count + 16'h0001;
                    set_low    = (count[7:0] == `T2C_BYTE_MAX);
                end
            end
        end
        else
        begin
            if (low_tick)
            begin
                if (count[7:0] == `T2C_BYTE_MAX)
                begin
                    next_count[7:0] = reload[7:0];
                    set_low         = 1'b1;
                end
                else
                begin
                    next_count[7:0] = count[7:0] + 8'h01;
                end
            end
            if (run && high_tick)
            begin
                if (count[15:8] == `T2C_BYTE_MAX)
                begin
                    next_count[15:8] = reload[15:8];
                    set_high         = 1'b1;
                end
                else
                begin
                    next_count[15:8] = count[15:8] + 8'h01;
                end
            end
        end
        if (capture)
        begin
            set_high = 1'b1;
        end
        // Software writes to the count bytes take priority over counting
        if (SFR_WR_IN && cntl_hit)
        begin
            next_count[7:0] = SFR_WDATA_IN;
        end
        if (SFR_WR_IN && cnth_hit)
        begin
            next_count[15:8] = SFR_WDATA_IN;
        end
    end

    // ****************************************************************
    // Reload next value
    // ****************************************************************
    always_comb
    begin
        next_reload = capture ? count : reload;
        if (SFR_WR_IN && rll_hit)
        begin
            next_reload[7:0] = SFR_WDATA_IN;
        end
        if (SFR_WR_IN && rlh_hit)
        begin
            next_reload[15:8] = SFR_WDATA_IN;
        end
    end

    // Interrupt request follows the flags, low flag only when enabled
    wire next_irq = TIMER_IRQ_ENABLE_IN &&
                    (timer_control_reg.high_overflow_flag ||
                     (timer_control_reg.low_byte_irq_enable &&
                      timer_control_reg.low_overflow_flag));

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge REF_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            timer_control_reg <= t2c_ctrl_s'(`T2C_CTRL_RESET);
            count             <= {`T2C_BYTE_RESET, `T2C_BYTE_RESET};
            reload            <= {`T2C_BYTE_RESET, `T2C_BYTE_RESET};
            SFR_RDATA_OUT     <= 8'h00;
            TIMER_IRQ_OUT     <= 1'b0;
        end
        else
        begin
            timer_control_reg <= next_ctrl;
            count             <= next_count;
            reload            <= next_reload;
            SFR_RDATA_OUT     <= read_mux;
            TIMER_IRQ_OUT     <= next_irq;
        end
    end

endmodule // t2c_timer

// ===== tb/t2c_timer_properties.sv
// Checker for the timer control block, bound to every t2c_timer.
// Assumes read data shows the register addressed one cycle earlier.
`timescale 1ns/100ps
`include "t2c_consts.svh"

module t2c_timer_properties
(
    input wire logic       REF_CLK_IN,
    input wire logic       RST_IN,
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic [7:0] SFR_PAGE_IN,
    input wire logic       SFR_WR_IN,
    input wire logic [7:0] SFR_WDATA_IN,
    input wire logic       SFR_BIT_WR_IN,
    input wire logic [2:0] SFR_BIT_SEL_IN,
    input wire logic       SFR_BIT_VAL_IN,
    input wire logic       TIMER_IRQ_ENABLE_IN,
    input wire logic [7:0] SFR_RDATA_OUT,
    input wire logic       TIMER_IRQ_OUT
);
    import t2c_pkg::*;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    wire  hit   = (SFR_PAGE_IN == `T2C_PAGE) && (SFR_ADDR_IN == `T2C_CTRL_ADDR);
    wire  quiet = !SFR_WR_IN && !SFR_BIT_WR_IN;
    logic rd_ok;
    always_ff @(posedge REF_CLK_IN or posedge RST_IN)
        if (RST_IN) rd_ok <= 1'b0;
        else rd_ok <= hit && quiet;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_UNUSED_READ: assert property ($past(hit) |-> !SFR_RDATA_OUT[1])
        else $error("unused control bit reads one");
    AST_OFF_PAGE_READ: assert property ($past(SFR_PAGE_IN) != 8'h00 |-> SFR_RDATA_OUT == 8'h00)
        else $error("read on another page not zero");
    AST_BYTE_WRITE: assert property (SFR_WR_IN && hit ##1 hit && quiet |=>
        (SFR_RDATA_OUT & 8'h3d) == ($past(SFR_WDATA_IN, 2) & 8'h3d)) else $error("control write lost");
    AST_BIT_WRITE: assert property (SFR_BIT_WR_IN && hit && SFR_BIT_SEL_IN inside {0, 2, 3, 4, 5}
        ##1 hit && quiet |=> SFR_RDATA_OUT[$past(SFR_BIT_SEL_IN, 2)] == $past(SFR_BIT_VAL_IN, 2))
        else $error("bit write lost");
    AST_IRQ_OFF: assert property (!TIMER_IRQ_ENABLE_IN |=> !TIMER_IRQ_OUT)
        else $error("interrupt while disabled");
    AST_IRQ_HIGH: assert property (rd_ok && SFR_RDATA_OUT[7] && TIMER_IRQ_ENABLE_IN && quiet
        ##1 TIMER_IRQ_ENABLE_IN |=> TIMER_IRQ_OUT) else $error("high flag gives no interrupt");
    AST_IRQ_LOW: assert property (rd_ok && SFR_RDATA_OUT[6] && SFR_RDATA_OUT[5] && TIMER_IRQ_ENABLE_IN
        && quiet ##1 TIMER_IRQ_ENABLE_IN |=> TIMER_IRQ_OUT) else $error("low flag gives no interrupt");
    AST_FLAGS_STAY: assert property (rd_ok && quiet ##1 hit && quiet |=>
        (SFR_RDATA_OUT[7:6] & $past(SFR_RDATA_OUT[7:6], 2)) == $past(SFR_RDATA_OUT[7:6], 2))
        else $error("flag cleared without a write");
    cover property (SFR_WR_IN && hit);
    cover property (rd_ok && SFR_RDATA_OUT[7]);
    cover property (TIMER_IRQ_OUT);
endmodule // t2c_timer_properties

bind t2c_timer t2c_timer_properties u_props (.*);

// ===== tb/t2c_cpu_model.sv
// CPU side of the special-function-register bus, driven through its tasks.
// Assumes every task is entered just after a rising edge of clk_in.
`timescale 1ns/100ps

module t2c_cpu_model
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic [7:0]      addr_out,
    output logic [7:0]      page_out,
    output logic            wr_out,
    output logic [7:0]      wdata_out,
    output logic            bit_wr_out,
    output logic [2:0]      bit_sel_out,
    output logic            bit_val_out
);
    initial
    begin
        addr_out = 8'h00;
        page_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        bit_wr_out = 1'b0;
        bit_sel_out = 3'h0;
        bit_val_out = 1'b0;
    end

    // ****************************************************************
    // Bus cycles, each taken at the next rising edge
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        page_out = 8'h00;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in) #1;
        wr_out = 1'b0;
        wdata_out = ~d;
        // Idle edge so a following write never re-raises the strobe in the same step
        @(posedge clk_in) #1;
    endtask
    task automatic bwr(input logic [2:0] b, input logic v);
        addr_out = 8'hc8;
        page_out = 8'h00;
        bit_sel_out = b;
        bit_val_out = v;
        bit_wr_out = 1'b1;
        @(posedge clk_in) #1;
        bit_wr_out = 1'b0;
        bit_val_out = ~v;
        @(posedge clk_in) #1;
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d);
        addr_out = a;
        page_out = p;
        @(posedge clk_in) #1;
        d = rdata_in;
    endtask
endmodule // t2c_cpu_model

// ===== tb/t2c_timer_bench.sv
// Self-checking bench for the timer control block and its CPU bus model.
// Assumes the design, package, checker and bus model are compiled first.
`timescale 1ns/100ps

module t2c_timer_bench;
    import t2c_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       irq_en = 1'b0;
    logic       fast_hi = 1'b0;
    logic       fast_lo = 1'b0;
    logic       ext = 1'b0;
    logic [7:0] addr, page, wdata, rdata;
    logic       wr, bwr, bval, irq;
    logic [2:0] bsel;
    int         n_errors = 0;
    int         tests_run = 0;
    always #10 clk = ~clk;
    t2c_cpu_model cpu (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .page_out(page), .wr_out(wr),
        .wdata_out(wdata), .bit_wr_out(bwr), .bit_sel_out(bsel), .bit_val_out(bval));
    t2c_timer dut (.REF_CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr), .SFR_PAGE_IN(page), .SFR_WR_IN(wr),
        .SFR_WDATA_IN(wdata), .SFR_BIT_WR_IN(bwr), .SFR_BIT_SEL_IN(bsel), .SFR_BIT_VAL_IN(bval),
        .TIMER_IRQ_ENABLE_IN(irq_en), .HIGH_FAST_CLOCK_SELECT_IN(fast_hi),
        .LOW_FAST_CLOCK_SELECT_IN(fast_lo), .EXT_CLK_IN(ext), .SFR_RDATA_OUT(rdata), .TIMER_IRQ_OUT(irq));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic ck(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        logic [7:0] v;
        cpu.rd(8'h00, a, v);
        check(v & m, exp);
    endtask
    task automatic run_for(input logic [7:0] base, input int n);
        // Run stays set for exactly n counting edges; each write takes two cycles
        cpu.wr(8'hc8, base | 8'h04);
        repeat (n - 2) @(posedge clk) #1;
        cpu.wr(8'hc8, base);
    endtask
    task automatic ext_pulses(input int n);
        repeat (2 * n)
        begin
            repeat (2) @(posedge clk) #1;
            ext = ~ext;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_and_map();
        logic [7:0] v;
        logic [7:0] regs [5] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};
        foreach (regs[i])
            ck(regs[i], 8'h00);
        cpu.rd(8'h01, 8'hc8, v);
        check(v, 8'h00);
        cpu.wr(8'hc8, 8'hff);
        ck(8'hc8, 8'hfd);
        cpu.wr(8'hc8, 8'h00);
        for (int b = 0; b < 6; b++)
        begin
            cpu.bwr(3'(b), 1'b1);
            ck(8'hc8, (b == 1) ? 8'h00 : 8'h01 << b);
            cpu.bwr(3'(b), 1'b0);
        end
    endtask
    task automatic t_word_mode();
        fast_lo = 1'b1;
        cpu.wr(8'hca, 8'h34);
        cpu.wr(8'hcb, 8'h12);
        cpu.wr(8'hcc, 8'hfe);
        cpu.wr(8'hcd, 8'h12);
        run_for(8'h00, 2);
        ck(8'hc8, 8'h40);
        ck(8'hcd, 8'h13);
        cpu.wr(8'hcc, 8'hfe);
        cpu.wr(8'hcd, 8'hff);
        run_for(8'h00, 2);
        repeat (20) @(posedge clk) #1;
        ck(8'hcc, 8'h34);
        ck(8'hcd, 8'h12);
        irq_en = 1'b1;
        ck(8'hc8, 8'hc0);
        repeat (3) @(posedge clk) #1;
        check({7'h0, irq}, 8'h01);
    endtask
    task automatic t_irq_paths();
        cpu.bwr(3'h7, 1'b0);
        cpu.bwr(3'h6, 1'b0);
        ck(8'hc8, 8'h00);
        cpu.wr(8'hc8, 8'h40);
        repeat (3) @(posedge clk) #1;
        check({7'h0, irq}, 8'h00);
        cpu.wr(8'hc8, 8'h60);
        ck(8'hc8, 8'h60);
        repeat (3) @(posedge clk) #1;
        check({7'h0, irq}, 8'h01);
        cpu.wr(8'hc8, 8'h00);
        repeat (3) @(posedge clk) #1;
        check({7'h0, irq}, 8'h00);
        irq_en = 1'b0;
    endtask
    task automatic t_split_mode();
        fast_hi = 1'b1;
        cpu.wr(8'hca, 8'h40);
        cpu.wr(8'hcb, 8'h80);
        cpu.wr(8'hcd, 8'hff);
        cpu.wr(8'hc8, 8'h08);
        repeat (300) @(posedge clk) #1;
        ck(8'hc8, 8'h48);
        ck(8'hcd, 8'hff);
        cpu.wr(8'hcd, 8'hfe);
        run_for(8'h08, 2);
        ck(8'hcd, 8'h80);
        ck(8'hc8, 8'h88, 8'hbf);
        cpu.wr(8'hcc, 8'hff);
        ck(8'hcc, 8'h40);
        cpu.wr(8'hc8, 8'h00);
        fast_hi = 1'b0;
        fast_lo = 1'b0;
    endtask
    task automatic t_slow_clocks();
        cpu.wr(8'hcd, 8'h00);
        cpu.wr(8'hcc, 8'h00);
        run_for(8'h00, 24);
        ck(8'hcc, 8'h02);
        cpu.wr(8'hcc, 8'h00);
        cpu.wr(8'hc8, 8'h05);
        ext_pulses(16);
        repeat (10) @(posedge clk) #1;
        cpu.wr(8'hc8, 8'h01);
        ck(8'hcc, 8'h02);
        ck(8'hca, 8'h40);
        fast_lo = 1'b1;
        cpu.wr(8'hcc, 8'h00);
        cpu.wr(8'hc8, 8'h14);
        ext_pulses(8);
        repeat (10) @(posedge clk) #1;
        cpu.bwr(3'h2, 1'b0);
        ck(8'hc8, 8'h90);
        ck(8'hcb, 8'h00);
        ck(8'hca, 8'h20, 8'he0);
    endtask

    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        t_reset_and_map();
        t_word_mode();
        t_irq_paths();
        t_split_mode();
        t_slow_clocks();
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule // t2c_timer_bench
